// [design/sac_top.sv]
// serial converter sequencer: result fifo and top level
`include "sac_regs.svh"

module sac_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r, rp_r, wp_nxt, rp_nxt;
    logic push, pop;
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
        out_valid = wp_r != rp_r;
        out_data = mem[rp_r[AW-1:0]];
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule : sac_fifo

// Operation
// - ignore control inputs until two sys rising and one falling edge after select low
// - data output floats on select high or eighth shift clock falling edge
// - end-of-conversion output goes high when a conversion finishes
// - route one of eleven inputs or self-test source, twelve channels in all
// - sampling starts only from a host access, never on its own
// - acquisition lasts 16 us, conversion finishes within 20 us
// - eight-bit successive approximation, one bit per step
// - address 1011 selects the self-test source
// - end-of-conversion goes low after the eighth shift clock falling edge; here only while the sequencer is idle
// - most significant result bit shows on data output at the next access, once select low is armed
// - above top reference gives all ones, below bottom gives all zeros
module sac_top #(
    parameter int ACQ_CYC = `SAC_ACQ_CYC,
    parameter int STEP_CYC = `SAC_STEP_CYC,
    parameter int FIFO_DEPTH = `SAC_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic io_clk,
    input wire logic cs_n,
    input wire logic addr_in,
    output logic data_out,
    output logic data_out_oe,
    output logic eoc,
    input wire logic cmp_above,
    output sac_pkg::sac_ana_s ana
);
    import sac_pkg::*;
    localparam int CONV_MAX_I = `SAC_CONV_MAX_CYC;

    function automatic logic [11:0] sac_decode(input logic [3:0] a);
        sac_decode = '0;
        if (a < 4'(`SAC_NUM_CHAN)) begin
            sac_decode[a] = 1'b1;
        end
    endfunction : sac_decode

    // select synchroniser: two rising edges then one falling edge
    logic cs_meta_r, cs_sync_r, armed_r, armed_d_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cs_meta_r <= 1'b1;
            cs_sync_r <= 1'b1;
            armed_d_r <= 1'b0;
        end else begin
            cs_meta_r <= cs_n;
            cs_sync_r <= cs_meta_r;
            armed_d_r <= armed_r;
        end
    end
    always_ff @(negedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= !cs_sync_r;
        end
    end

    // link side; armed_r is settled long before the first shift edge
    // because the host waits the select setup time, so no extra stages
    logic [2:0] rise_cnt_r, rise_cnt_nxt;
    logic [3:0] fall_cnt_r, fall_cnt_nxt;
    logic [3:0] addr_sh_r, addr_sh_nxt;
    logic [7:0] out_sh_r, out_sh_nxt;
    logic [7:0] out_word_r;
    logic eighth_r, ev_tog_r, ev_tog_nxt;
    always_comb begin
        rise_cnt_nxt = rise_cnt_r;
        addr_sh_nxt = addr_sh_r;
        if (armed_r && rise_cnt_r < 3'(`SAC_ADDR_BITS)) begin
            rise_cnt_nxt = rise_cnt_r + 3'h1;
            addr_sh_nxt = {addr_sh_r[2:0], addr_in};
        end
        fall_cnt_nxt = fall_cnt_r;
        out_sh_nxt = out_sh_r;
        ev_tog_nxt = ev_tog_r;
        if (armed_r && fall_cnt_r < 4'(`SAC_FRAME_CLKS)) begin
            fall_cnt_nxt = fall_cnt_r + 4'h1;
            out_sh_nxt = (fall_cnt_r == 4'h0) ? {out_word_r[6:0], 1'b0}
                                              : {out_sh_r[6:0], 1'b0};
            if (fall_cnt_r == 4'(`SAC_FRAME_CLKS - 1)) begin
                ev_tog_nxt = !ev_tog_r;
            end
        end
    end
    always_ff @(posedge io_clk or posedge cs_n) begin
        if (cs_n) begin
            rise_cnt_r <= 3'h0;
        end else begin
            rise_cnt_r <= rise_cnt_nxt;
        end
    end
    // address and event toggle survive select high for the sys side
    always_ff @(posedge io_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_sh_r <= 4'h0;
        end else begin
            addr_sh_r <= addr_sh_nxt;
        end
    end
    always_ff @(negedge io_clk or posedge cs_n) begin
        if (cs_n) begin
            fall_cnt_r <= 4'h0;
            out_sh_r <= 8'h00;
            eighth_r <= 1'b0;
        end else begin
            fall_cnt_r <= fall_cnt_nxt;
            out_sh_r <= out_sh_nxt;
            eighth_r <= (fall_cnt_nxt == 4'(`SAC_FRAME_CLKS));
        end
    end
    always_ff @(negedge io_clk or negedge reset_n) begin
        if (!reset_n) begin
            ev_tog_r <= 1'b0;
        end else begin
            ev_tog_r <= ev_tog_nxt;
        end
    end
    // msb shows once select low is armed, without waiting for a shift edge
    always_comb begin
        data_out = (fall_cnt_r == 4'h0) ? out_word_r[7] : out_sh_r[7];
        data_out_oe = armed_r && !eighth_r && !cs_n;
    end

    // frame-end event crosses by toggle
    logic ev_meta_r, ev_sync_r, ev_prev_r, ev_pulse;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ev_meta_r <= 1'b0;
            ev_sync_r <= 1'b0;
            ev_prev_r <= 1'b0;
        end else begin
            ev_meta_r <= ev_tog_r;
            ev_sync_r <= ev_meta_r;
            ev_prev_r <= ev_sync_r;
        end
    end
    assign ev_pulse = ev_sync_r != ev_prev_r;

    // sequencer
    sac_state_e st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] res_r, res_nxt, word_nxt;
    logic [3:0] addr_r, addr_nxt;
    logic eoc_r, eoc_nxt;
    sac_ana_s ana_r, ana_nxt;
    logic f_in_ready, f_out_valid, f_pop;
    logic [7:0] f_out_data;
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        res_nxt = res_r;
        addr_nxt = addr_r;
        eoc_nxt = eoc_r;
        ana_nxt = ana_r;
        f_pop = armed_r && !armed_d_r;
        word_nxt = (f_pop && f_out_valid) ? f_out_data : out_word_r;
        case (st_r)
            ST_IDLE: begin
                if (ev_pulse) begin
                    eoc_nxt = 1'b0;
                    addr_nxt = addr_sh_r;
                    ana_nxt.chan = sac_decode(addr_sh_r);
                    ana_nxt.sample = 1'b1;
                    cnt_nxt = 16'h0;
                    st_nxt = ST_ACQ;
                end
            end
            ST_ACQ: begin
                cnt_nxt = cnt_r + 16'h1;
                if (cnt_r == 16'(ACQ_CYC - 1)) begin
                    ana_nxt.sample = 1'b0;
                    ana_nxt.trial = 8'h80;
                    res_nxt = 8'h00;
                    bit_nxt = 3'h7;
                    cnt_nxt = 16'h0;
                    st_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                cnt_nxt = cnt_r + 16'h1;
                if (cnt_r == 16'(STEP_CYC - 1)) begin
                    cnt_nxt = 16'h0;
                    // keep the trial bit while the input sits above it
                    res_nxt = cmp_above ? ana_r.trial : res_r;
                    if (bit_r == 3'h0) begin
                        st_nxt = ST_DONE;
                    end else begin
                        bit_nxt = bit_r - 3'h1;
                        ana_nxt.trial = res_nxt | (8'h01 << (bit_r - 3'h1));
                    end
                end
            end
            ST_DONE: begin
                // stalls here while the result fifo is full
                if (f_in_ready) begin
                    eoc_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_IDLE;
            cnt_r <= 16'h0;
            bit_r <= 3'h0;
            res_r <= 8'h00;
            addr_r <= 4'h0;
            eoc_r <= 1'b1;
            ana_r <= '0;
            out_word_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            res_r <= res_nxt;
            addr_r <= addr_nxt;
            eoc_r <= eoc_nxt;
            ana_r <= ana_nxt;
            out_word_r <= word_nxt;
        end
    end
    assign eoc = eoc_r;
    assign ana = ana_r;

    sac_fifo #(
        .WIDTH(`SAC_DATA_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(st_r == ST_DONE),
        .in_ready(f_in_ready),
        .in_data(res_r),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out_data)
    );

    // checks
    logic [15:0] acq_len_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acq_len_r <= 16'h0;
        end else begin
            acq_len_r <= ana_r.sample ? acq_len_r + 16'h1 : 16'h0;
        end
    end
    sequence s_conv_start;
        $fell(ana_r.sample);
    endsequence
    sequence s_conv_end;
        st_r == ST_DONE;
    endsequence
    chk_eoc_fall: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ev_pulse && st_r == ST_IDLE) |=> !eoc_r)
        else $error("end flag did not fall on frame end");
    chk_acq_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(ana_r.sample) |-> acq_len_r == 16'(ACQ_CYC))
        else $error("acquisition length wrong");
    chk_conv_time: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_conv_start |-> ##[1:CONV_MAX_I] s_conv_end)
        else $error("conversion overran its budget");
    chk_eoc_rise: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(eoc_r) |-> $past(st_r == ST_DONE && f_in_ready))
        else $error("end flag rose without a result");
    chk_self_test: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(ana_r.sample) |->
        ana_r.chan[11] == (addr_r == `SAC_SELF_TEST_ADDR))
        else $error("self-test channel select wrong");
    chk_no_self_start: assert property (@(posedge clk_sys)
        disable iff (!reset_n) $rose(ana_r.sample) |-> $past(ev_pulse))
        else $error("sampling began without an access");
    chk_arm_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(armed_r) |-> !cs_sync_r && $past(!cs_n, 2))
        else $error("access armed before select settled");
    chk_float_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cs_n |-> !data_out_oe)
        else $error("data output driven while deselected");
    chk_chan_onehot: assert property (@(posedge clk_sys)
        disable iff (!reset_n) $onehot0(ana_r.chan))
        else $error("more than one channel routed");
endmodule : sac_top

// [design/sac_regs.svh]
// timing counts and field constants for the serial converter sequencer
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_SYS_PERIOD_NS 40
`define SAC_ACQ_TIME_NS 16000
`define SAC_CONV_MAX_NS 20000
`define SAC_ACQ_CYC ((`SAC_ACQ_TIME_NS + `SAC_SYS_PERIOD_NS - 1) / `SAC_SYS_PERIOD_NS)
`define SAC_CONV_MAX_CYC (`SAC_CONV_MAX_NS / `SAC_SYS_PERIOD_NS)
`define SAC_STEP_CYC 8
`define SAC_ADDR_BITS 4
`define SAC_DATA_BITS 8
`define SAC_NUM_CHAN 12
`define SAC_SELF_TEST_ADDR 4'hB
`define SAC_FRAME_CLKS 8
`define SAC_FIFO_DEPTH 8
`endif

// [design/sac_pkg.sv]
// types shared by the converter sequencer
package sac_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ACQ = 4'b0010,
        ST_CONV = 4'b0100,
        ST_DONE = 4'b1000
    } sac_state_e;
    typedef struct packed {
        logic [11:0] chan;
        logic sample;
        logic [7:0] trial;
    } sac_ana_s;
endpackage : sac_pkg

// [dv/sac_host.sv]
// host model: select, shift clock and address out, result bits in
module sac_host (
    output logic cs_n,
    output logic io_clk,
    output logic addr_in,
    input wire logic data_out,
    input wire logic data_out_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic held = 1'b0;
    // a floating line wanders, so never reuse the last driven bit
    wire line = data_out_oe ? data_out : ~held;
    initial begin
        // a select edge at start clears the link counters
        cs_n = 1'b0;
        io_clk = 1'b0;
        addr_in = 1'b0;
        #2 cs_n = 1'b1;
    end
    always @(data_out or data_out_oe) begin
        if (data_out_oe) held = data_out;
    end
    task automatic xfer(input logic [3:0] a, input int nclk,
                        input bit early, output logic [7:0] res);
        cs_n = 1'b0;
        if (early) begin
            repeat (2) begin
                addr_in = 1'b1;
                #7.5 io_clk = 1'b1;
                #7.5 io_clk = 1'b0;
            end
        end
        #3800;
        for (int k = 0; k < nclk; k++) begin
            addr_in = (k < 4) ? a[3-k] : ~addr_in;
            #7.5 io_clk = 1'b1;
            res = {res[6:0], line};
            #7.5 io_clk = 1'b0;
        end
    endtask : xfer
    task automatic drop_sel();
        #20 cs_n = 1'b1;
        addr_in = ~addr_in;
    endtask : drop_sel
endmodule : sac_host

// [dv/tb_sac_top.sv]
// testbench for the converter sequencer
module tb_sac_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sac_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b1;
    logic cmp_above = 1'b0;
    logic io_clk, cs_n, addr_in, data_out, data_out_oe, eoc;
    sac_ana_s ana;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;

    always #20 clk_sys = ~clk_sys;

    sac_host host (.cs_n(cs_n), .io_clk(io_clk), .addr_in(addr_in),
        .data_out(data_out), .data_out_oe(data_out_oe));
    sac_top #(.ACQ_CYC(4), .STEP_CYC(2), .FIFO_DEPTH(8)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .io_clk(io_clk),
        .cs_n(cs_n), .addr_in(addr_in), .data_out(data_out),
        .data_out_oe(data_out_oe), .eoc(eoc), .cmp_above(cmp_above),
        .ana(ana));

    function automatic logic [8:0] level(int i);
        if (i == 0) return 9'h000;
        if (i == 10) return 9'h12C;
        if (i == 11) return 9'h080;
        return 9'(i * 23 + 1);
    endfunction : level

    // comparator keeps a bit while input exceeds trial: code is level-1
    function automatic logic [7:0] code(logic [3:0] a);
        logic [8:0] v;
        v = (a > 4'hB) ? 9'h000 : level(int'(a));
        if (v == 9'h000) return 8'h00;
        if (v > 9'h0FF) return 8'hFF;
        return 8'(v - 9'h001);
    endfunction : code

    always @(negedge clk_sys) begin : analog
        logic [8:0] v;
        v = 9'h000;
        for (int i = 0; i < 12; i++) begin
            if (ana.chan[i]) v = level(i);
        end
        cmp_above <= v > {1'b0, ana.trial};
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic frame(input logic [3:0] a, input bit early,
                         input logic [7:0] exp);
        logic [7:0] res;
        int n, lo, smp;
        host.xfer(a, 8, early, res);
        #5 check(16'(data_out_oe), 16'h0);
        check(16'(res), 16'(exp));
        host.drop_sel();
        n = 0;
        lo = -1;
        smp = 0;
        while (!(lo >= 0 && eoc === 1'b1) && n < 900) begin
            @(negedge clk_sys);
            n++;
            smp += int'(ana.sample === 1'b1);
            if (lo < 0 && eoc === 1'b0) lo = n;
        end
        check(16'(lo > 0 && lo <= 13), 16'h1);
        check(16'(eoc), 16'h1);
        check(16'(smp), 16'h4);
        check(16'(n - lo < 500), 16'h1);
    endtask : frame

    task automatic t_abort();
        logic [7:0] res;
        logic s;
        s = 1'b0;
        host.xfer(4'h3, 4, 1'b0, res);
        #5 check(16'(data_out_oe), 16'h1);
        host.drop_sel();
        #5 check(16'(data_out_oe), 16'h0);
        repeat (200) begin
            @(negedge clk_sys);
            s = s | ana.sample | ~eoc;
        end
        check(16'(s), 16'h0);
        $display("abort test done");
    endtask : t_abort

    task automatic t_chan();
        logic [7:0] exp;
        exp = 8'h00;
        for (int a = 0; a < 17; a++) begin
            frame(4'(a), a == 5, exp);
            exp = code(4'(a));
        end
        $display("channel sweep done");
    endtask : t_chan

    // result path through the fifo: a cut access must not lose the result
    task automatic t_fifo();
        logic [7:0] res;
        frame(4'h7, 1'b0, code(4'h0));
        host.xfer(4'h9, 4, 1'b0, res);
        check(16'(res[3:0]), 16'(code(4'h7) >> 4));
        host.drop_sel();
        #5 check(16'(data_out_oe), 16'h0);
        repeat (100) @(negedge clk_sys);
        check(16'(eoc), 16'h1);
        frame(4'h2, 1'b0, code(4'h7));
        frame(4'h9, 1'b1, code(4'h2));
        check(16'(ana.chan), 16'h0200);
        $display("fifo test done");
    endtask : t_fifo

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        #1 reset_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_abort();
        t_chan();
        t_fifo();
        print_verdict();
    end
endmodule : tb_sac_top
